// >>> ppc_dev.sv
`timescale 1ns/1ps
`default_nettype none
module ppc_dev (
    input  wire logic              mclk,
    input  wire logic              nrst,
    ppc_link_if.dev                lnk,
    input  wire logic              hv_present,
    input  wire logic              thermal_trip,
    output logic [ppc_pkg::NCH-1:0] tx_pos,
    output logic [ppc_pkg::NCH-1:0] tx_neg,
    output logic [ppc_pkg::NCH-1:0] tr_switch_control,
    output logic                   mem_clear_busy
);
    import ppc_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_PLAY, ST_CLEAR} ppc_state_t;

    // pin index inside the synchroniser vector
    localparam int PIN_SCLK = 0;
    localparam int PIN_SEN  = 1;
    localparam int PIN_SDIN = 2;
    localparam int PIN_SYNC = 3;
    localparam int NPIN     = 4;

    logic [NPIN-1:0] s1_ff, s2_ff, s3_ff, flt_ff, prv_ff, nxt_flt;

    // three-stage synchroniser; a level counts once stages two and three agree
    always_comb begin
        for (int i = 0; i < NPIN; i++) begin
            nxt_flt[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : flt_ff[i];
        end
    end

    always_ff @(posedge mclk) begin
        s1_ff <= {lnk.sync, lnk.sdin, lnk.sen_n, lnk.sclk};
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
        if (!nrst) begin
            flt_ff <= 4'h2;
            prv_ff <= 4'h2;
        end else begin
            flt_ff <= nxt_flt;
            prv_ff <= flt_ff;
        end
    end

    logic sclk_rise, sen_fall, sen_rise, sync_rise;
    assign sclk_rise = flt_ff[PIN_SCLK] & ~prv_ff[PIN_SCLK];
    assign sen_fall  = ~flt_ff[PIN_SEN] & prv_ff[PIN_SEN];
    assign sen_rise  = flt_ff[PIN_SEN] & ~prv_ff[PIN_SEN];
    assign sync_rise = flt_ff[PIN_SYNC] & ~prv_ff[PIN_SYNC];

    // serial shift and frame check
    logic [FRAME_W-1:0] shr_ff, nxt_shr;
    logic [CNT_W-1:0]   bcnt_ff, nxt_bcnt;
    logic               cfg_err_ff, nxt_cfg_err;
    logic               frame_ok, frame_exec;

    assign frame_ok   = (bcnt_ff == CNT_W'(FRAME_W)) && (^shr_ff == 1'b0);
    assign frame_exec = sen_rise & frame_ok;

    always_comb begin
        nxt_shr     = shr_ff;
        nxt_bcnt    = bcnt_ff;
        nxt_cfg_err = cfg_err_ff;
        if (sen_fall) begin
            nxt_bcnt = '0;
        end else if (sclk_rise && !flt_ff[PIN_SEN]) begin
            nxt_shr = {shr_ff[FRAME_W-2:0], flt_ff[PIN_SDIN]};
            if (bcnt_ff != CNT_W'(FRAME_W)) begin
                nxt_bcnt = bcnt_ff + 1'b1;
            end else begin
                nxt_bcnt = bcnt_ff;
            end
        end
        if (sen_rise && !frame_ok) begin
            nxt_cfg_err = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            shr_ff     <= '0;
            bcnt_ff    <= '0;
            cfg_err_ff <= 1'b0;
        end else begin
            shr_ff     <= nxt_shr;
            bcnt_ff    <= nxt_bcnt;
            cfg_err_ff <= nxt_cfg_err;
        end
    end

    logic [OP_W-1:0]   f_op;
    logic [ADDR_W-1:0] f_addr;
    logic [DATA_W-1:0] f_data;
    assign f_op   = shr_ff[OP_MSB -: OP_W];
    assign f_addr = shr_ff[ADDR_MSB -: ADDR_W];
    assign f_data = shr_ff[DATA_MSB -: DATA_W];

    // programmable settings, all restored by nrst
    logic [NCH-1:0]    pd_ff, inv_ff, tre_ff, trd_ff;
    logic [NCH-1:0]    nxt_pd, nxt_inv, nxt_tre, nxt_trd;
    logic [SLOT_W-1:0] ptr_ff, nxt_ptr;
    logic [GRP_IDX_W-1:0] grp;
    assign grp = f_addr[GRP_IDX_W-1:0];

    always_comb begin
        nxt_pd  = pd_ff;
        nxt_inv = inv_ff;
        nxt_tre = tre_ff;
        nxt_trd = trd_ff;
        nxt_ptr = ptr_ff;
        if (frame_exec) begin
            unique case (f_op)
                OP_SET_PTR: nxt_ptr = f_data[SLOT_W-1:0];
                // bit 0 of a group is its lowest channel
                OP_WR_PD:   nxt_pd[grp*GRP_W +: GRP_W]  = f_data[GRP_W-1:0];
                OP_WR_INV:  nxt_inv[grp*GRP_W +: GRP_W] = f_data[GRP_W-1:0];
                OP_WR_TRE:  nxt_tre[grp*GRP_W +: GRP_W] = f_data[GRP_W-1:0];
                OP_WR_TRD:  nxt_trd[grp*GRP_W +: GRP_W] = f_data[GRP_W-1:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            pd_ff  <= CH_CTRL_RST;
            inv_ff <= CH_CTRL_RST;
            tre_ff <= CH_CTRL_RST;
            trd_ff <= CH_CTRL_RST;
            ptr_ff <= PTR_RST;
        end else begin
            pd_ff  <= nxt_pd;
            inv_ff <= nxt_inv;
            tre_ff <= nxt_tre;
            trd_ff <= nxt_trd;
            ptr_ff <= nxt_ptr;
        end
    end

    // pattern memory: no reset, contents undefined until cleared or loaded
    logic [WORD_W-1:0] mem [NPAGE*NSLOT];
    logic              mem_we;
    logic [MEM_AW-1:0] mem_waddr;
    logic [WORD_W-1:0] mem_wdata;

    always_ff @(posedge mclk) begin
        if (mem_we) begin
            mem[mem_waddr] <= mem_wdata;
        end
    end

    // transmit and clear sequencer
    ppc_state_t        st_ff, nxt_st;
    logic [PAGE_W-1:0] tr_ff, nxt_tr;
    logic [DUR_W-1:0]  dcnt_ff, nxt_dcnt;
    logic [SLOT_W-1:0] act_ptr_ff, nxt_act_ptr;
    logic [MEM_AW-1:0] clr_ff, nxt_clr;
    logic [WORD_W-1:0] cur_word;
    logic [LVL_W-1:0]  cur_lvl;
    logic              therm_ff;

    // the pointer is latched at sync so a mid-event change waits for the next event
    assign cur_word = mem[{tr_ff, act_ptr_ff}];
    assign cur_lvl  = (st_ff == ST_PLAY) ? cur_word[LVL_LSB +: LVL_W] : LVL_GND;

    always_comb begin
        nxt_st      = st_ff;
        nxt_tr      = tr_ff;
        nxt_dcnt    = dcnt_ff;
        nxt_act_ptr = act_ptr_ff;
        nxt_clr     = clr_ff;
        mem_we      = 1'b0;
        mem_waddr   = {f_addr[PAGE_W+SLOT_W-1:SLOT_W], f_addr[SLOT_W-1:0]};
        mem_wdata   = f_data[WORD_W-1:0];
        unique case (st_ff)
            ST_IDLE: begin
                if (frame_exec && f_op == OP_MEM_RST) begin
                    nxt_st  = ST_CLEAR;
                    nxt_clr = '0;
                end else if (frame_exec && f_op == OP_WR_PAT) begin
                    mem_we = 1'b1;
                end else if (sync_rise && hv_present && !therm_ff) begin
                    nxt_st      = ST_PLAY;
                    nxt_tr      = '0;
                    nxt_dcnt    = '0;
                    nxt_act_ptr = ptr_ff;
                end
            end
            ST_PLAY: begin
                if (therm_ff || !hv_present) begin
                    nxt_st = ST_IDLE;
                end else if (dcnt_ff == cur_word[DUR_W-1:0]) begin
                    nxt_dcnt = '0;
                    if (cur_word[WORD_LAST] || tr_ff == PAGE_LAST) begin
                        nxt_st = ST_IDLE;
                    end else begin
                        nxt_tr = tr_ff + 1'b1;
                    end
                end else begin
                    nxt_dcnt = dcnt_ff + 1'b1;
                end
            end
            ST_CLEAR: begin
                mem_we    = 1'b1;
                mem_waddr = clr_ff;
                mem_wdata = MEM_CLEAR_WORD;
                nxt_clr   = clr_ff + 1'b1;
                if (clr_ff == MEM_LAST_ADDR) begin
                    nxt_st = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            st_ff      <= ST_IDLE;
            tr_ff      <= '0;
            dcnt_ff    <= '0;
            act_ptr_ff <= PTR_RST;
            clr_ff     <= '0;
        end else begin
            st_ff      <= nxt_st;
            tr_ff      <= nxt_tr;
            dcnt_ff    <= nxt_dcnt;
            act_ptr_ff <= nxt_act_ptr;
            clr_ff     <= nxt_clr;
        end
    end

    // channel drive: inversion swaps polarity, power-down forces ground
    logic [NCH-1:0] pos_ff, neg_ff, tr_switch_control_ff, nxt_pos, nxt_neg, nxt_tr_switch_control;
    logic           txi_ff, clr_busy_ff;

    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            nxt_pos[c]  = ~pd_ff[c] & (inv_ff[c] ? (cur_lvl == LVL_NEG) : (cur_lvl == LVL_POS));
            nxt_neg[c]  = ~pd_ff[c] & (inv_ff[c] ? (cur_lvl == LVL_POS) : (cur_lvl == LVL_NEG));
            // forced disable wins so a conflicting setting never shorts the receiver
            nxt_tr_switch_control[c] = ~trd_ff[c] & (tre_ff[c] | (st_ff != ST_PLAY));
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            pos_ff      <= '0;
            neg_ff      <= '0;
            tr_switch_control_ff     <= '0;
            txi_ff      <= 1'b0;
            therm_ff    <= 1'b0;
            clr_busy_ff <= 1'b0;
        end else begin
            pos_ff      <= nxt_pos;
            neg_ff      <= nxt_neg;
            tr_switch_control_ff     <= nxt_tr_switch_control;
            txi_ff      <= (st_ff == ST_PLAY);
            therm_ff    <= thermal_trip;
            clr_busy_ff <= (st_ff == ST_CLEAR);
        end
    end

    assign tx_pos                         = pos_ff;
    assign tx_neg                         = neg_ff;
    assign tr_switch_control              = tr_switch_control_ff;
    assign mem_clear_busy                 = clr_busy_ff;
    assign lnk.thermal_shutdown_flag      = therm_ff;
    assign lnk.config_check_error         = cfg_err_ff;
    assign lnk.transmit_receive_indicator = txi_ff;
endmodule // ppc_dev
`default_nettype wire

// >>> ppc_pkg.sv
`default_nettype none
package ppc_pkg;
    // serial frame layout, sent msb first: op, address, data, parity
    localparam int FRAME_W    = 29;
    localparam int OP_W       = 4;
    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 16;
    localparam int OP_MSB     = 28;
    localparam int ADDR_MSB   = 24;
    localparam int DATA_MSB   = 16;
    localparam int CNT_W      = 5;
    // channels and per-channel groups
    localparam int NCH        = 64;
    localparam int GRP_W      = 4;
    localparam int NGRP       = 16;
    localparam int GRP_IDX_W  = 4;
    // pattern memory: page = transition index, slot = pattern number
    localparam int NPAGE      = 16;
    localparam int NSLOT      = 16;
    localparam int PAGE_W     = 4;
    localparam int SLOT_W     = 4;
    localparam int MEM_AW     = 8;
    localparam int WORD_W     = 11;
    localparam int DUR_W      = 8;
    localparam int LVL_W      = 2;
    localparam int WORD_LAST  = 10;
    localparam int LVL_LSB    = 8;
    localparam logic [WORD_W-1:0] MEM_CLEAR_WORD = 11'h000;
    localparam logic [MEM_AW-1:0] MEM_LAST_ADDR  = 8'hFF;
    localparam logic [PAGE_W-1:0] PAGE_LAST      = 4'hF;
    // output levels
    localparam logic [LVL_W-1:0] LVL_GND = 2'h0;
    localparam logic [LVL_W-1:0] LVL_POS = 2'h1;
    localparam logic [LVL_W-1:0] LVL_NEG = 2'h2;
    // reset values of programmable settings
    localparam logic [NCH-1:0]    CH_CTRL_RST = 64'h0000_0000_0000_0000;
    localparam logic [SLOT_W-1:0] PTR_RST     = 4'h0;
    // host timing defaults, in mclk cycles; the frame gap counts sclk half periods
    localparam int SCLK_HALF_DEF   = 4;
    localparam int FRAME_GAP_DEF   = 8;
    localparam int SYNC_PERIOD_DEF = 4000;
    localparam int SYNC_HIGH_DEF   = 8;
    typedef enum logic [OP_W-1:0] {
        OP_NOP     = 4'h0,
        OP_WR_PAT  = 4'h1,
        OP_SET_PTR = 4'h2,
        OP_WR_PD   = 4'h3,
        OP_WR_INV  = 4'h4,
        OP_WR_TRE  = 4'h5,
        OP_WR_TRD  = 4'h6,
        OP_MEM_RST = 4'h7
    } ppc_op_t;
endpackage
`default_nettype wire

// >>> ppc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ppc_link_if;
    logic sclk;
    logic sen_n;
    logic sdin;
    logic sync;
    logic thermal_shutdown_flag;
    logic config_check_error;
    logic transmit_receive_indicator;
    modport dev (input sclk, input sen_n, input sdin, input sync,
                 output thermal_shutdown_flag, output config_check_error, output transmit_receive_indicator);
    modport host (output sclk, output sen_n, output sdin, output sync,
                  input thermal_shutdown_flag, input config_check_error, input transmit_receive_indicator);
endinterface
`default_nettype wire

// >>> ppc_host.sv
`timescale 1ns/1ps
`default_nettype none
module ppc_host #(
    parameter int SCLK_HALF   = ppc_pkg::SCLK_HALF_DEF,
    parameter int FRAME_GAP   = ppc_pkg::FRAME_GAP_DEF,
    parameter int SYNC_PERIOD = ppc_pkg::SYNC_PERIOD_DEF,
    parameter int SYNC_HIGH   = ppc_pkg::SYNC_HIGH_DEF
) (
    input  wire logic                      mclk,
    input  wire logic                      nrst,
    ppc_link_if.host                       lnk,
    input  wire logic                      cmd_valid,
    output logic                           cmd_ready,
    input  wire ppc_pkg::ppc_op_t          cmd_op,
    input  wire logic [ppc_pkg::ADDR_W-1:0] cmd_addr,
    input  wire logic [ppc_pkg::DATA_W-1:0] cmd_data,
    input  wire logic                      auto_pointer,
    input  wire logic                      sync_enable,
    output logic                           dev_thermal,
    output logic                           dev_cfg_err,
    output logic                           dev_transmitting
);
    import ppc_pkg::*;

    typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_GAP} ppc_hstate_t;

    // slow rates come from enable pulses, never a derived clock
    logic [15:0] div_ff, nxt_div;
    logic        tick;
    assign tick = (div_ff == 16'(SCLK_HALF - 1));

    ppc_hstate_t        hs_ff, nxt_hs;
    logic [FRAME_W-1:0] sh_ff, nxt_sh;
    logic [CNT_W-1:0]   cnt_ff, nxt_cnt;
    logic               sclk_ff, nxt_sclk, sen_n_ff, nxt_sen_n;
    logic               pend_ff, nxt_pend;
    logic [SLOT_W-1:0]  pslot_ff, nxt_pslot;
    logic [FRAME_W-2:0] body;
    logic [FRAME_W-2:0] pbody;

    assign body      = {cmd_op, cmd_addr, cmd_data};
    assign pbody     = {OP_SET_PTR, ADDR_W'(0), DATA_W'(pslot_ff)};
    assign cmd_ready = (hs_ff == H_IDLE) && !pend_ff;

    always_comb begin
        nxt_hs    = hs_ff;
        nxt_sh    = sh_ff;
        nxt_cnt   = cnt_ff;
        nxt_sclk  = sclk_ff;
        nxt_sen_n = sen_n_ff;
        nxt_pend  = pend_ff;
        nxt_pslot = pslot_ff;
        nxt_div   = tick ? 16'h0000 : div_ff + 16'h0001;
        unique case (hs_ff)
            H_IDLE: begin
                nxt_div = 16'h0000;
                if (pend_ff) begin
                    // follow a finished save with a pointer move to it
                    nxt_sh    = {pbody, ^pbody};
                    nxt_pend  = 1'b0;
                    nxt_hs    = H_SHIFT;
                    nxt_sen_n = 1'b0;
                    nxt_cnt   = '0;
                end else if (cmd_valid) begin
                    nxt_sh    = {body, ^body};
                    nxt_hs    = H_SHIFT;
                    nxt_sen_n = 1'b0;
                    nxt_cnt   = '0;
                    // last word of a pattern saved across the pages
                    if (auto_pointer && cmd_op == OP_WR_PAT && cmd_data[WORD_LAST]) begin
                        nxt_pend  = 1'b1;
                        nxt_pslot = cmd_addr[SLOT_W-1:0];
                    end
                end
            end
            H_SHIFT: begin
                if (tick) begin
                    nxt_sclk = ~sclk_ff;
                    if (sclk_ff) begin
                        nxt_sh  = {sh_ff[FRAME_W-2:0], 1'b0};
                        nxt_cnt = cnt_ff + 1'b1;
                        if (cnt_ff == CNT_W'(FRAME_W - 1)) begin
                            nxt_sen_n = 1'b1;
                            nxt_hs    = H_GAP;
                            nxt_cnt   = '0;
                        end
                    end
                end
            end
            H_GAP: begin
                if (tick) begin
                    nxt_cnt = cnt_ff + 1'b1;
                    if (cnt_ff == CNT_W'(FRAME_GAP - 1)) begin
                        nxt_hs = H_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            hs_ff    <= H_IDLE;
            sh_ff    <= '0;
            cnt_ff   <= '0;
            sclk_ff  <= 1'b0;
            sen_n_ff <= 1'b1;
            pend_ff  <= 1'b0;
            pslot_ff <= '0;
            div_ff   <= 16'h0000;
        end else begin
            hs_ff    <= nxt_hs;
            sh_ff    <= nxt_sh;
            cnt_ff   <= nxt_cnt;
            sclk_ff  <= nxt_sclk;
            sen_n_ff <= nxt_sen_n;
            pend_ff  <= nxt_pend;
            pslot_ff <= nxt_pslot;
            div_ff   <= nxt_div;
        end
    end

    // sync stays low until enabled, then a periodic pulse
    logic [31:0] sper_ff, nxt_sper;
    logic        sync_ff, nxt_sync;

    always_comb begin
        nxt_sper = (sper_ff == 32'(SYNC_PERIOD - 1)) ? 32'h0000_0000 : sper_ff + 32'h0000_0001;
        nxt_sync = sync_enable && (sper_ff < 32'(SYNC_HIGH));
        if (!sync_enable) begin
            nxt_sper = 32'h0000_0000;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            sper_ff <= 32'h0000_0000;
            sync_ff <= 1'b0;
        end else begin
            sper_ff <= nxt_sper;
            sync_ff <= nxt_sync;
        end
    end

    // status pins pass three stages before use
    logic [2:0] t1_ff, t2_ff, t3_ff, st_ff, nxt_st;
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            nxt_st[i] = (t2_ff[i] == t3_ff[i]) ? t3_ff[i] : st_ff[i];
        end
    end

    always_ff @(posedge mclk) begin
        t1_ff <= {lnk.transmit_receive_indicator, lnk.config_check_error, lnk.thermal_shutdown_flag};
        t2_ff <= t1_ff;
        t3_ff <= t2_ff;
        if (!nrst) begin
            st_ff <= 3'h0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign dev_thermal      = st_ff[0];
    assign dev_cfg_err      = st_ff[1];
    assign dev_transmitting = st_ff[2];
    assign lnk.sclk         = sclk_ff;
    assign lnk.sen_n        = sen_n_ff;
    assign lnk.sdin         = sh_ff[FRAME_W-1];
    assign lnk.sync         = sync_ff;
endmodule // ppc_host
`default_nettype wire

// >>> ppc_link_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ppc_link_checker (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic sen_n,
    input wire logic sdin,
    input wire logic sync,
    input wire logic thermal_shutdown_flag,
    input wire logic config_check_error,
    input wire logic transmit_receive_indicator
);
    logic [4:0] bit_cnt_ff;
    logic [7:0] sync_age_ff;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // bits per frame, and age of the last sync edge (saturates so stale syncs never match)
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            bit_cnt_ff  <= 5'h00;
            sync_age_ff <= 8'hFF;
        end else begin
            if ($fell(sen_n)) bit_cnt_ff <= 5'h00;
            else if ($rose(sclk)) bit_cnt_ff <= bit_cnt_ff + 5'h01;
            if ($rose(sync)) sync_age_ff <= 8'h00;
            else if (sync_age_ff != 8'hFF) sync_age_ff <= sync_age_ff + 8'h01;
        end
    end
    property p_rst_idle;
        disable iff (1'b0) !nrst |=> sen_n && !sclk && !sync && !thermal_shutdown_flag
            && !config_check_error && !transmit_receive_indicator;
    endproperty
    property p_cfg_clean; !config_check_error; endproperty
    property p_sclk_framed; $rose(sclk) |-> !sen_n; endproperty
    property p_sclk_high; $rose(sclk) |-> sclk [*4] ##1 !sclk; endproperty
    property p_sdin_hold; sclk |-> $stable(sdin); endproperty
    property p_frame_len; $rose(sen_n) |-> bit_cnt_ff == 5'h1D; endproperty
    property p_tri_thermal; $rose(transmit_receive_indicator) |-> !thermal_shutdown_flag; endproperty
    property p_tri_after_sync; $rose(transmit_receive_indicator) |-> sync_age_ff inside {[3:12]}; endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("link not idle after reset");
    a_cfg_clean: assert property (p_cfg_clean) else $error("config error on clean link");
    a_sclk_framed: assert property (p_sclk_framed) else $error("sclk outside frame");
    a_sclk_high: assert property (p_sclk_high) else $error("sclk high time wrong");
    a_sdin_hold: assert property (p_sdin_hold) else $error("sdin moved while sclk high");
    a_frame_len: assert property (p_frame_len) else $error("frame bit count wrong");
    a_tri_thermal: assert property (p_tri_thermal) else $error("transmit during thermal");
    a_tri_after_sync: assert property (p_tri_after_sync) else $error("transmit without sync");
    c_tx: cover property ($rose(transmit_receive_indicator));
    c_frame: cover property ($rose(sen_n));
    c_hot: cover property ($rose(thermal_shutdown_flag));
endmodule // ppc_link_checker
`default_nettype wire

// >>> pulse_pattern_channel_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pulse_pattern_channel_ctrl_tb_top;
    import ppc_pkg::*;
    typedef struct {
        ppc_op_t     op;
        logic [7:0]  addr;
        logic [15:0] data;
        logic [3:0]  exp;
    } ppc_row_t;
    logic            mclk, nrst, cmd_valid, cmd_ready, auto_pointer, sync_enable;
    logic            hv_present, thermal_trip, mem_clear_busy, dev_thermal, dev_cfg_err, dev_transmitting;
    ppc_op_t         cmd_op;
    logic [7:0]      cmd_addr;
    logic [15:0]     cmd_data;
    logic [NCH-1:0]  tx_pos, tx_neg, tr_switch_control, seen;
    int              error_cnt, checked, n;
    ppc_row_t        rows [6];
    ppc_link_if lnk ();
    ppc_dev u_ppc_dev (.mclk(mclk), .nrst(nrst), .lnk(lnk.dev), .hv_present(hv_present),
        .thermal_trip(thermal_trip), .tx_pos(tx_pos), .tx_neg(tx_neg),
        .tr_switch_control(tr_switch_control), .mem_clear_busy(mem_clear_busy));
    // short sync period keeps the run small
    ppc_host #(.SYNC_PERIOD(200)) u_ppc_host (.mclk(mclk), .nrst(nrst), .lnk(lnk.host),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_data(cmd_data), .auto_pointer(auto_pointer), .sync_enable(sync_enable),
        .dev_thermal(dev_thermal), .dev_cfg_err(dev_cfg_err), .dev_transmitting(dev_transmitting));
    ppc_link_checker u_ppc_link_checker (.mclk(mclk), .nrst(nrst), .sclk(lnk.sclk), .sen_n(lnk.sen_n),
        .sdin(lnk.sdin), .sync(lnk.sync), .thermal_shutdown_flag(lnk.thermal_shutdown_flag),
        .config_check_error(lnk.config_check_error),
        .transmit_receive_indicator(lnk.transmit_receive_indicator));
    // clock
    always #4 mclk = ~mclk;
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // every task returns 1 ns after an edge, so inputs never race the clock
    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    task automatic wait_ready;
        for (int k = 0; k < 2000 && !cmd_ready; k++) tick(1);
        tick(2);
    endtask
    task automatic issue(input ppc_op_t op, input logic [7:0] a, input logic [15:0] d);
        cmd_op = op;
        cmd_addr = a;
        cmd_data = d;
        cmd_valid = 1'b1;
        for (int k = 0; k < 2000 && !cmd_ready; k++) tick(1);
        tick(1);
        cmd_valid = 1'b0;
    endtask
    task automatic send(input ppc_op_t op, input logic [7:0] a, input logic [15:0] d);
        issue(op, a, d);
        wait_ready();
    endtask
    // gather pulses and transmit-state cycles over a span
    task automatic window(input int k);
        seen = '0;
        n = 0;
        repeat (k) begin
            tick(1);
            seen |= tx_pos | tx_neg;
            if (lnk.transmit_receive_indicator) n++;
        end
    endtask
    task automatic wait_pulse;
        for (int k = 0; k < 600 && !tx_pos[1]; k++) tick(1);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // watchdog against a hung handshake
    initial begin
        repeat (40000) @(posedge mclk);
        error_cnt++;
        test_done();
    end
    initial begin
        {mclk, nrst, cmd_valid, sync_enable, hv_present, thermal_trip} = 6'h00;
        {cmd_addr, cmd_data} = 24'h000000;
        cmd_op = OP_NOP;
        auto_pointer = 1'b1;
        rows = '{'{OP_WR_TRD, 8'h00, 16'h0005, 4'hA}, '{OP_WR_TRE, 8'h00, 16'h000F, 4'hA},
                 '{OP_WR_TRD, 8'h0F, 16'h0008, 4'h7}, '{OP_WR_TRD, 8'h00, 16'h0000, 4'hF},
                 '{OP_NOP, 8'h00, 16'h0005, 4'hF}, '{OP_WR_TRD, 8'h0F, 16'h0000, 4'hF}};
        // every device output register, switch drive too, is held low while nrst is asserted
        tick(10);
        chk(tr_switch_control, 64'h0);
        chk(tx_pos | tx_neg, 64'h0);
        chk(64'(mem_clear_busy), 64'h0);
        nrst = 1'b1;
        tick(2);
        $display("reset test ended");
        foreach (rows[r]) begin
            send(rows[r].op, rows[r].addr, rows[r].data);
            chk(64'(tr_switch_control[rows[r].addr[3:0]*4 +: 4]), 64'(rows[r].exp));
        end
        $display("table test ended");
        hv_present = 1'b1;
        issue(OP_MEM_RST, 8'h00, 16'h0000);
        for (int k = 0; k < 1000 && !mem_clear_busy; k++) tick(1);
        n = 0;
        while (mem_clear_busy && n < 2000) begin
            n++;
            tick(1);
        end
        chk(64'(n), 64'h100);
        sync_enable = 1'b1;
        window(300);
        chk(seen, 64'h0);
        chk(64'(n != 0), 64'h1);
        sync_enable = 1'b0;
        tick(40);
        $display("memory clear test ended");
        send(OP_WR_PAT, 8'h03, 16'h0102);
        send(OP_WR_PAT, 8'h13, 16'h0600);
        send(OP_WR_PD, 8'h00, 16'h0005);
        send(OP_WR_INV, 8'h01, 16'h0001);
        hv_present = 1'b0;
        sync_enable = 1'b1;
        window(300);
        chk(seen | 64'(n), 64'h0);
        sync_enable = 1'b0;
        hv_present = 1'b1;
        tick(20);
        sync_enable = 1'b1;
        wait_pulse();
        chk(tx_pos, ~64'h15);
        chk(tx_neg, 64'h10);
        chk(tr_switch_control, 64'hF);
        chk(64'(lnk.transmit_receive_indicator), 64'h1);
        n = 0;
        while (tx_pos[1] && n < 20) begin
            n++;
            tick(1);
        end
        chk(64'(n), 64'h3);
        n = 0;
        while (tx_neg[1] && n < 20) begin
            n++;
            tick(1);
        end
        chk(64'(n), 64'h1);
        // filtered copy of the transmit state lags the pin by four cycles
        chk(64'(dev_transmitting), 64'h1);
        wait_pulse();
        chk(64'(tx_pos[1]), 64'h1);
        send(OP_SET_PTR, 8'h00, 16'h0000);
        window(300);
        chk(seen, 64'h0);
        $display("pattern test ended");
        send(OP_SET_PTR, 8'h00, 16'h0003);
        thermal_trip = 1'b1;
        tick(12);
        chk({62'h0, lnk.thermal_shutdown_flag, dev_thermal}, 64'h3);
        window(300);
        chk(seen | 64'(n), 64'h0);
        thermal_trip = 1'b0;
        $display("thermal test ended");
        nrst = 1'b0;
        tick(10);
        chk(tr_switch_control, 64'h0);
        chk(tx_pos | tx_neg, 64'h0);
        nrst = 1'b1;
        tick(2);
        send(OP_SET_PTR, 8'h00, 16'h0003);
        wait_pulse();
        chk(64'(tx_pos[1]), 64'h1);
        // power-down, inversion and forced enable were all cleared by the reset
        chk(tx_pos, ~64'h0);
        chk(tx_neg | tr_switch_control, 64'h0);
        chk(64'(dev_cfg_err), 64'h0);
        sync_enable = 1'b0;
        $display("second reset test ended");
        test_done();
    end
endmodule // pulse_pattern_channel_ctrl_tb_top
`default_nettype wire
